// *** verilog/irv_pkg.sv ***
// Purpose: shared constants for the role select and interrupt vector block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package irv_pkg;
   // register byte offsets
   localparam logic [7:0] IRV_OFF_MODE = 8'h00;
   localparam logic [7:0] IRV_OFF_VECTOR = 8'h04;
   localparam logic [7:0] IRV_OFF_EXTMODE = 8'h08;
   localparam logic [7:0] IRV_OFF_STATUS = 8'h0C;
   localparam logic [7:0] IRV_OFF_MASK = 8'h10;
   localparam logic [7:0] IRV_OFF_ROLE = 8'h14;
   // mode register fields
   localparam int IRV_MODE_DIR_BIT = 0;
   localparam int IRV_MODE_FDF_BIT = 1;
   localparam int IRV_MODE_MST_BIT = 2;
   localparam int IRV_MODE_RST_BIT = 3;
   // extended mode fields and reset value
   localparam int IRV_EXT_COMPAT_BIT = 0;
   localparam int IRV_EXT_IGNORE_NOACK_MODE_BIT = 1;
   localparam logic [1:0] IRV_EXT_RESET = 2'h1;
   // event codes
   localparam logic [2:0] IRV_EV_NONE = 3'h0;
   localparam logic [2:0] IRV_EV_AL = 3'h1;
   localparam logic [2:0] IRV_EV_NACK = 3'h2;
   localparam logic [2:0] IRV_EV_ACCESS_READY_EVENT = 3'h3;
   localparam logic [2:0] IRV_EV_RRDY = 3'h4;
   localparam logic [2:0] IRV_EV_XRDY = 3'h5;
   localparam logic [2:0] IRV_EV_SCD = 3'h6;
   localparam logic [2:0] IRV_EV_AAS = 3'h7;
   localparam int IRV_NUM_EV = 7;
   // link clock period seen by the edge finder
   localparam int IRV_LINK_NS = 160;
   localparam int IRV_CLK_NS = 20;
   localparam int IRV_LINK_CYC = (IRV_LINK_NS + IRV_CLK_NS - 1) / IRV_CLK_NS;
endpackage : irv_pkg

// *** verilog/irv_core.sv ***
// Purpose: transmitter/receiver role choice, prioritised interrupt vector, extended mode
// Assumes: pclk 50 MHz; link_scl and event inputs come from the serial engine or pins
// Notes: events are level pulses from the engine, all sampled through two flops
`timescale 1ns/1ps
module irv_core
   import irv_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_scl,
   input wire logic link_sda_ack,
   input wire logic slave_read_req,
   input wire logic ev_arb_lost,
   input wire logic ev_data_ack,
   input wire logic ev_rx_ready,
   input wire logic ev_stop_det,
   input wire logic ev_addressed,
   input wire logic ev_tx_load,
   output logic is_transmitter,
   output logic stop_request,
   output logic irq
);

   // two-flop synchronisers for every outside input
   // link lines idle high, so their flops start high: no false edge after reset
   logic [8:0] sync1_reg;
   logic [8:0] sync2_reg;
   logic [8:0] prev_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 9'h180;
         sync2_reg <= 9'h180;
         prev_reg <= 9'h180;
      end else begin
         sync1_reg <= {link_scl, link_sda_ack, slave_read_req, ev_arb_lost, ev_data_ack,
                       ev_rx_ready, ev_stop_det, ev_addressed, ev_tx_load};
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // rising edges of synchronised levels
   logic [8:0] rise;
   assign rise = sync2_reg & ~prev_reg;

   // named synchronised levels
   logic sda_ack_s;
   logic read_req_s;
   logic data_ack_s;
   assign sda_ack_s = sync2_reg[7]; // 1 means no-acknowledge
   assign read_req_s = sync2_reg[6];
   assign data_ack_s = sync2_reg[4]; // ack slot still open

   // named event edges
   logic scl_rise;
   logic arb_lost_rise;
   logic data_ack_rise;
   logic rx_ready_rise;
   logic stop_det_rise;
   logic addressed_rise;
   logic tx_load_rise;
   assign scl_rise = rise[8];
   assign arb_lost_rise = rise[5];
   assign data_ack_rise = rise[4];
   assign rx_ready_rise = rise[3];
   assign stop_det_rise = rise[2];
   assign addressed_rise = rise[1];
   assign tx_load_rise = rise[0];

   // registers
   logic [3:0] mode_reg;
   logic [1:0] ext_reg;
   logic [6:0] status_reg;
   logic [6:0] mask_reg;
   logic [2:0] code_reg;

   logic master_select;
   logic free_format_select;
   logic direction_select;
   logic module_rst;
   assign direction_select = mode_reg[IRV_MODE_DIR_BIT];
   assign free_format_select = mode_reg[IRV_MODE_FDF_BIT];
   assign master_select = mode_reg[IRV_MODE_MST_BIT];
   assign module_rst = ~mode_reg[IRV_MODE_RST_BIT];
   logic compat_tx_ready_mode;
   logic ignore_noack_mode;
   assign compat_tx_ready_mode = ext_reg[IRV_EXT_COMPAT_BIT];
   assign ignore_noack_mode = ext_reg[IRV_EXT_IGNORE_NOACK_MODE_BIT];

   // apb strobes
   logic wr_en;
   logic rd_en;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;

   // register selects from the byte address
   logic sel_mode;
   logic sel_vector;
   logic sel_extmode;
   logic sel_status;
   logic sel_mask;
   assign sel_mode = (paddr == IRV_OFF_MODE);
   assign sel_vector = (paddr == IRV_OFF_VECTOR);
   assign sel_extmode = (paddr == IRV_OFF_EXTMODE);
   assign sel_status = (paddr == IRV_OFF_STATUS);
   assign sel_mask = (paddr == IRV_OFF_MASK);

   // role selection
   logic trx_next;
   always_comb begin
      if (free_format_select)
         trx_next = direction_select;
      else if (master_select)
         trx_next = direction_select;
      else
         trx_next = read_req_s;
   end

   // current role toward the serial engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         is_transmitter <= 1'b0;
      else
         is_transmitter <= trx_next;
   end

   // acknowledge bit sampled when ev_data_ack rises and again on each link clock rise while it stays high
   logic ack_phase;
   logic nack_seen;
   logic ack_seen;
   assign ack_phase = data_ack_rise | (data_ack_s & scl_rise);
   assign nack_seen = ack_phase & sda_ack_s;
   assign ack_seen = ack_phase & ~sda_ack_s;

   logic master_tx;
   logic slave_tx;
   assign master_tx = master_select & trx_next;
   assign slave_tx = ~master_select & trx_next;

   // unignored nack stops a master transmitter
   logic nack_stop;
   assign nack_stop = master_tx & nack_seen & ~ignore_noack_mode;

   // tx-ready source; the compat bit only matters as slave transmitter
   logic xrdy_set;
   always_comb begin
      if (slave_tx)
         xrdy_set = compat_tx_ready_mode ? tx_load_rise : ack_seen;
      else
         xrdy_set = tx_load_rise;
   end

   // event set vector, index = code-1
   logic [6:0] set_vec;
   always_comb begin
      set_vec = 7'h00;
      set_vec[IRV_EV_AL - 3'h1] = arb_lost_rise;
      set_vec[IRV_EV_NACK - 3'h1] = nack_stop;
      set_vec[IRV_EV_ACCESS_READY_EVENT - 3'h1] = nack_stop;
      set_vec[IRV_EV_RRDY - 3'h1] = rx_ready_rise;
      set_vec[IRV_EV_XRDY - 3'h1] = xrdy_set;
      set_vec[IRV_EV_SCD - 3'h1] = stop_det_rise;
      set_vec[IRV_EV_AAS - 3'h1] = addressed_rise;
   end

   // stop request toward the engine on unignored nack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         stop_request <= 1'b0;
      else
         stop_request <= nack_stop & ~module_rst;
   end

   // highest pending flag, lowest code wins
   logic [2:0] top_code;
   always_comb begin
      top_code = IRV_EV_NONE;
      for (int i = IRV_NUM_EV - 1; i >= 0; i--) begin
         if (status_reg[i] & mask_reg[i])
            top_code = 3'(i + 1);
      end
   end

   // code handed out by this read, held in prdata since the setup edge
   // clearing by it, not by top_code now, keeps a late higher event pending
   logic vec_done;
   logic [2:0] reported_code;
   assign vec_done = rd_en & sel_vector & pready;
   assign reported_code = prdata[2:0];

   // clears: the reported vector flag and write-one-to-clear status bits
   logic [6:0] clr_vec;
   always_comb begin
      clr_vec = 7'h00;
      if (vec_done && reported_code != IRV_EV_NONE)
         clr_vec[reported_code - 3'h1] = 1'b1;
      if (wr_en && sel_status)
         clr_vec = clr_vec | pwdata[6:0];
   end

   // next status, set wins over a clear in the same cycle
   logic [6:0] status_next;
   always_comb begin
      if (module_rst)
         status_next = 7'h00;
      else
         status_next = (status_reg & ~clr_vec) | set_vec;
   end

   // sticky status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         status_reg <= 7'h00;
      else
         status_reg <= status_next;
   end

   // vector code mirrors highest pending flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         code_reg <= IRV_EV_NONE;
      else
         code_reg <= top_code;
   end

   // interrupt level: any unmasked flag still set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(status_next & mask_reg);
   end

   // mode register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mode_reg <= 4'h0;
      else if (wr_en && sel_mode)
         mode_reg <= pwdata[3:0];
   end

   // extended mode register, upper bits not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ext_reg <= IRV_EXT_RESET;
      else if (wr_en && sel_extmode)
         ext_reg <= pwdata[1:0];
   end

   // interrupt mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mask_reg <= 7'h00;
      else if (wr_en && sel_mask)
         mask_reg <= pwdata[6:0];
   end

   // vector word: reserved upper bits always zero, writes never reach it
   logic [31:0] vector_word;
   assign vector_word = {29'h0, top_code};

   // read data mux
   logic [31:0] rd_mux;
   logic map_hit;
   always_comb begin
      rd_mux = 32'h00000000;
      map_hit = 1'b1;
      unique case (paddr)
         IRV_OFF_MODE: rd_mux[3:0] = mode_reg;
         IRV_OFF_VECTOR: rd_mux = vector_word;
         IRV_OFF_EXTMODE: rd_mux[1:0] = ext_reg;
         IRV_OFF_STATUS: rd_mux[6:0] = status_reg;
         IRV_OFF_MASK: rd_mux[6:0] = mask_reg;
         IRV_OFF_ROLE: rd_mux[3:0] = {code_reg, is_transmitter};
         default: map_hit = 1'b0;
      endcase
   end

   // setup cycle of a transfer, the edge the answer is launched on
   logic setup_phase;
   assign setup_phase = psel & ~penable;

   // ready for exactly the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pready <= 1'b0;
      else
         pready <= setup_phase;
   end

   // read data only while ready stands, zero otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else
         prdata <= (setup_phase & ~pwrite) ? rd_mux : 32'h00000000;
   end

   // error with ready for an unmapped offset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pslverr <= 1'b0;
      else
         pslverr <= setup_phase & ~map_hit;
   end

   // limits: a write or read takes effect only on the cycle pready is high
   // read data is captured at the setup edge, so a vector read reports the
   // code pending then and clears exactly that flag at completion
   // an event landing between setup and completion stays pending
   // the run bit low clears status and holds irq and stop low
   // unmapped offsets read zero, answer with an error and ignore writes
endmodule : irv_core

// *** test/irv_props_properties.sv ***
// Purpose: port checks for irv_core
// Assumes: APB answer one cycle after setup
// Notes: mode and extended mode are shadowed from writes
`timescale 1ns/1ps
module irv_props
   import irv_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic slave_read_req,
   input wire logic is_transmitter,
   input wire logic stop_request
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] mode_q;
   logic [1:0] ext_q;
   wire wr = pready && pwrite;
   wire rd = pready && !pwrite;
   // shadow copies of mode and extended mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 4'h0;
         ext_q <= IRV_EXT_RESET;
      end else if (wr && paddr == IRV_OFF_MODE) begin
         mode_q <= pwdata[3:0];
      end else if (wr && paddr == IRV_OFF_EXTMODE) begin
         ext_q <= pwdata[1:0];
      end
   end
   sequence s_fixed;
      $stable(mode_q) && mode_q[3] && mode_q[2:1] != 2'h0;
   endsequence
   property p_ready; psel && !penable |=> pready; endproperty
   property p_one; pready |=> !pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_idle; !pready |-> prdata == 32'h0; endproperty
   property p_vec; rd && paddr == IRV_OFF_VECTOR |-> prdata[31:3] == 29'h0; endproperty
   property p_ext;
      rd && paddr == IRV_OFF_EXTMODE |-> prdata == {30'h0, ext_q};
   endproperty
   property p_fixed; s_fixed [*3] |-> is_transmitter == mode_q[0]; endproperty
   property p_slave;
      ($stable(mode_q) && mode_q[3] && mode_q[2:1] == 2'h0 && $stable(slave_read_req)) [*5]
         |-> is_transmitter == slave_read_req;
   endproperty
   property p_ign; (ext_q[1] && mode_q[3]) [*6] |-> !stop_request; endproperty
   property p_stop; stop_request |-> mode_q[2] && is_transmitter; endproperty
   a_ready: assert property (p_ready) else $error("no answer after setup");
   a_one: assert property (p_one) else $error("ready longer than one cycle");
   a_err: assert property (p_err) else $error("error without ready");
   a_idle: assert property (p_idle) else $error("read data outside access");
   a_vec: assert property (p_vec) else $error("vector upper bits set");
   a_ext: assert property (p_ext) else $error("extended mode readback");
   a_fixed: assert property (p_fixed) else $error("fixed role wrong");
   a_slave: assert property (p_slave) else $error("slave role wrong");
   a_ign: assert property (p_ign) else $error("stop while ignoring");
   a_stop: assert property (p_stop) else $error("stop outside master tx");
endmodule : irv_props
bind irv_core irv_props irv_props_inst (.*);

// *** test/irv_bus_model.sv ***
// Purpose: far side of the two-wire bus
// Assumes: link clock 160 ns, idle high outside frames
// Notes: ack line released to pull-up level
`timescale 1ns/1ps
module irv_bus_model (
   output logic link_scl,
   output logic link_sda_ack,
   output logic ev_data_ack
);
   // idle bus: both lines pulled high
   initial begin
      link_scl = 1'b1;
      link_sda_ack = 1'b1;
      ev_data_ack = 1'b0;
   end
   // eight data clocks then the ack slot
   task automatic frame(input logic nack);
      for (int i = 0; i < 9; i++) begin
         #80 link_scl = 1'b0;
         if (i == 8) begin
            link_sda_ack = nack;
            ev_data_ack = 1'b1;
         end
         #80 link_scl = 1'b1;
      end
      #80 link_sda_ack = 1'b1;
      ev_data_ack = 1'b0;
   endtask : frame
endmodule : irv_bus_model

// *** test/irv_core_bench.sv ***
// Purpose: register-level tests of irv_core
// Assumes: pclk 20 ns
// Notes: events held four cycles
`timescale 1ns/1ps
module irv_core_bench;
   import irv_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, rd_req, err;
   logic pready, pslverr, scl, sda, dack, is_tx, stop, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [4:0] ev;
   logic [31:0] codes [5] = '{32'h1, 32'h4, 32'h6, 32'h7, 32'h0};
   int error_cnt = 0;
   int n_checks = 0;
   int stop_cnt = 0;
   // count stop request pulses toward the engine
   always @(posedge pclk) begin
      if (stop === 1'b1) stop_cnt++;
   end
   irv_core irv_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_scl(scl), .link_sda_ack(sda), .slave_read_req(rd_req),
      .ev_arb_lost(ev[0]), .ev_data_ack(dack), .ev_rx_ready(ev[1]), .ev_stop_det(ev[2]),
      .ev_addressed(ev[3]), .ev_tx_load(ev[4]), .is_transmitter(is_tx),
      .stop_request(stop), .irq(irq));
   irv_bus_model irv_bus_model_inst (.link_scl(scl), .link_sda_ack(sda), .ev_data_ack(dack));
   // clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask : chk
   // one APB transfer, bounded wait for ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         report_and_stop();
      end
      @(posedge pclk);
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rdata);
   endtask : rdc
   task automatic pulse(input logic [4:0] m);
      ev <= m;
      repeat (4) @(posedge pclk);
      ev <= 5'h0;
      repeat (6) @(posedge pclk);
   endtask : pulse
   task automatic frm(input logic nack);
      #5 irv_bus_model_inst.frame(nack);
      repeat (8) @(posedge pclk);
   endtask : frm
   // main sequence
   initial begin
      {psel, penable, pwrite, rd_req, presetn} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ev = 5'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(IRV_OFF_VECTOR, 32'h0);
      rdc(IRV_OFF_EXTMODE, 32'h1);
      apb(1'b1, IRV_OFF_VECTOR, 32'hFFFFFFFF);
      rdc(IRV_OFF_VECTOR, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("slave error", 32'h1, {31'h0, err});
      rd_req <= 1'b1;
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, IRV_OFF_MODE, 32'h8 | m);
         repeat (6) @(posedge pclk);
         chk("role", {31'h0, (m[2] | m[1]) ? m[0] : 1'b1}, {31'h0, is_tx});
      end
      rd_req <= 1'b0;
      apb(1'b1, IRV_OFF_MODE, 32'h8);
      repeat (6) @(posedge pclk);
      chk("role", 32'h0, {31'h0, is_tx});
      apb(1'b1, IRV_OFF_MASK, 32'h7F);
      pulse(5'h0F);
      for (int i = 0; i < 5; i++) begin
         rdc(IRV_OFF_VECTOR, codes[i]);
         repeat (3) @(posedge pclk);
         chk("irq", {31'h0, i < 3}, {31'h0, irq});
      end
      apb(1'b1, IRV_OFF_EXTMODE, 32'h0);
      apb(1'b1, IRV_OFF_MODE, 32'hD);
      frm(1'b1);
      chk("stop pulses", 32'h2, stop_cnt);
      rdc(IRV_OFF_VECTOR, 32'h2);
      rdc(IRV_OFF_VECTOR, 32'h3);
      apb(1'b1, IRV_OFF_EXTMODE, 32'h2);
      frm(1'b1);
      chk("stop pulses", 32'h2, stop_cnt);
      rdc(IRV_OFF_VECTOR, 32'h0);
      apb(1'b1, IRV_OFF_EXTMODE, 32'h0);
      apb(1'b1, IRV_OFF_MODE, 32'h8);
      rd_req <= 1'b1;
      pulse(5'h10);
      rdc(IRV_OFF_VECTOR, 32'h0);
      frm(1'b0);
      rdc(IRV_OFF_VECTOR, 32'h5);
      apb(1'b1, IRV_OFF_EXTMODE, 32'h1);
      pulse(5'h10);
      rdc(IRV_OFF_VECTOR, 32'h5);
      apb(1'b1, IRV_OFF_MASK, 32'h0);
      pulse(5'h08);
      chk("irq", 32'h0, {31'h0, irq});
      rdc(IRV_OFF_STATUS, 32'h40);
      apb(1'b1, IRV_OFF_STATUS, 32'h40);
      rdc(IRV_OFF_STATUS, 32'h0);
      report_and_stop();
   end
endmodule : irv_core_bench
